// File: src/oss_consts.svh
// Overview of operation
// - resonator modes count 1024 crystal input edges before clock is stable
// - count starts after power-on (after power-up delay if enabled) and wake
// - execution is held while the start-up count runs
// - external logic clock mode skips the start-up count entirely
// - external logic clock drives input pin; output pin becomes general I/O
// - fully static: a stopped clock keeps all state, resumes unchanged
// - resonator mode picks low, medium or high amplifier gain
// - resistor-capacitor mode drives output pin with clock divided by four
// - resistor-capacitor I/O mode frees output pin as general I/O
// - internal clock-out mode frees input pin, outputs internal clock over four
// - internal I/O mode frees both clock pins as general I/O
// - fast internal oscillator feeds postscaler choosing one of seven rates
// - fast oscillator on when select nonzero and clock select or two-speed
// - slow internal oscillator is a second internal source
// - status bit shows fast internal oscillator stable
// - trim value is five-bit two's complement, resets to zero
// - trim write takes effect with no completion indication
// - trim never touches the slow oscillator
// - one select bit chooses configured external or internal source
// - internal system clock rate follows the frequency select field
// - select 111 is top rate halving to 001; 000 slow; resets 110
// - select bit 1 means internal clock, 0 configured source
// - start-up source flag 1 on configured clock, 0 on internal
// - trim 00000 calibrated, 01111 maximum, 10000 minimum
`ifndef OSS_CONSTS_SVH
`define OSS_CONSTS_SVH
`define OSS_ADDR_CTRL   8'h00
`define OSS_ADDR_TRIM   8'h04
`define OSS_ADDR_CFG    8'h08
`define OSS_ADDR_STAT   8'h0c
`define OSS_IFS_LSB     4
`define OSS_STARTUP_SOURCE_STATUS_FLAG_BIT    3
`define OSS_FSTB_BIT    2
`define OSS_SSTB_BIT    1
`define OSS_SEL_BIT     0
`define OSS_TWOSPD_BIT  3
`define OSS_POWER_UP_DELAY_TIMER_BIT    4
`define OSS_IFS_RST     3'h6
`define OSS_IFS_SLOW    3'h0
`define OSS_IFS_TOP     3'h7
`define OSS_SEL_RST     1'h0
`define OSS_TRIM_RST    5'h00
`define OSS_MODE_RST    3'h7
`define OSS_STARTUP_CNT 11'h400
`define OSS_GAIN_OFF    2'h0
`define OSS_GAIN_LOW    2'h1
`define OSS_GAIN_MID    2'h2
`define OSS_GAIN_HIGH   2'h3
`endif

// File: src/oss_pkg.sv
package oss_pkg;
  typedef enum logic [2:0] {
    OSS_WATCH   = 3'h0,
    OSS_MEDIUM  = 3'h1,
    OSS_HIGH    = 3'h2,
    OSS_EXTCLK  = 3'h3,
    OSS_RESCAP  = 3'h4,
    OSS_RCAP_IO = 3'h5,
    OSS_INT_OUT = 3'h6,
    OSS_INT_IO  = 3'h7
  } oss_mode_t;
  typedef enum logic [1:0] {
    OSS_BOOT  = 2'h0,
    OSS_WAIT  = 2'h1,
    OSS_COUNT = 2'h3,
    OSS_RUN   = 2'h2
  } oss_state_t;
endpackage

// File: src/oss_top.sv
`timescale 1ns/1ns
`include "oss_consts.svh"
module oss_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              por_pulse,
  input  wire logic              wake_pulse,
  input  wire logic              power_up_delay_timer_done,
  input  wire logic              watchdog_enable,
  input  wire logic              crystal_input_pin,
  input  wire logic              internal_clock_pin,
  input  wire logic              fast_osc_ready,
  input  wire logic              slow_osc_ready,
  output logic                   exec_hold,
  output logic                   amp_enable,
  output logic      [1:0]        amp_gain,
  output logic                   fast_osc_enable,
  output logic                   slow_osc_enable,
  output logic      [2:0]        postscale_shift,
  output logic                   use_slow_osc,
  output logic      [4:0]        trim_bits,
  output logic                   sys_clock_internal,
  output logic                   crystal_output_pin_o,
  output logic                   crystal_output_pin_oe,
  output logic                   out_pin_gpio,
  output logic                   in_pin_gpio
);

  // ----------------------------------------
  // registers and synchronisers
  // ----------------------------------------
  logic [2:0]         ifs_reg;
  logic               sel_reg;
  logic [2:0]         mode_reg;
  logic               twospd_reg;
  logic               power_up_delay_timer_en_reg;
  logic [3:0]         s1_reg;
  logic [3:0]         s2_reg;
  logic [1:0]         s3_reg;
  logic               xtal_edge;
  logic               int_edge;
  logic               reson;
  logic               ext_src;
  logic               tick;
  logic [1:0]         div_reg;
  logic [1:0]         div_next;
  logic [10:0]        cnt_reg;
  logic [10:0]        cnt_next;
  logic               evt;
  oss_pkg::oss_state_t state_reg;
  oss_pkg::oss_state_t state_next;
  oss_pkg::oss_state_t boot_tgt;
  logic               wr_en;
  logic               setup;
  logic [31:0]        rd_data;
  logic               hit;
  logic               startup_source_status_flag;

  // two flops per asynchronous input
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 2'h0;
    end else begin
      s1_reg <= {slow_osc_ready, fast_osc_ready,
                 internal_clock_pin, crystal_input_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg[1:0];
    end
  end

  assign xtal_edge = s2_reg[0] & ~s3_reg[0];
  assign int_edge  = s2_reg[1] & ~s3_reg[1];

  assign reson = (mode_reg == oss_pkg::OSS_WATCH) ||
                 (mode_reg == oss_pkg::OSS_MEDIUM) ||
                 (mode_reg == oss_pkg::OSS_HIGH);

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  always_comb begin
    rd_data = 32'h0000_0000;
    hit     = 1'b1;
    case (paddr)
      `OSS_ADDR_CTRL: begin
        rd_data[`OSS_IFS_LSB+:3]  = ifs_reg;
        rd_data[`OSS_STARTUP_SOURCE_STATUS_FLAG_BIT]    = startup_source_status_flag;
        rd_data[`OSS_FSTB_BIT]    = s2_reg[2];
        rd_data[`OSS_SSTB_BIT]    = s2_reg[3];
        rd_data[`OSS_SEL_BIT]     = sel_reg;
      end
      `OSS_ADDR_TRIM: rd_data[4:0] = trim_bits;
      `OSS_ADDR_CFG: begin
        rd_data[2:0]              = mode_reg;
        rd_data[`OSS_TWOSPD_BIT]  = twospd_reg;
        rd_data[`OSS_POWER_UP_DELAY_TIMER_BIT]    = power_up_delay_timer_en_reg;
      end
      `OSS_ADDR_STAT: rd_data[0] = exec_hold;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // control writes; state simply holds when no clock arrives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ifs_reg     <= `OSS_IFS_RST;
      sel_reg     <= `OSS_SEL_RST;
      trim_bits   <= `OSS_TRIM_RST;
      mode_reg    <= `OSS_MODE_RST;
      twospd_reg  <= 1'b0;
      power_up_delay_timer_en_reg <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `OSS_ADDR_CTRL) begin
        ifs_reg <= pwdata[`OSS_IFS_LSB+:3];
        sel_reg <= pwdata[`OSS_SEL_BIT];
      end
      if (paddr == `OSS_ADDR_TRIM) begin
        trim_bits <= pwdata[4:0];
      end
      if (paddr == `OSS_ADDR_CFG) begin
        mode_reg    <= pwdata[2:0];
        twospd_reg  <= pwdata[`OSS_TWOSPD_BIT];
        power_up_delay_timer_en_reg <= pwdata[`OSS_POWER_UP_DELAY_TIMER_BIT];
      end
    end
  end

  // ----------------------------------------
  // start-up sequencing
  // ----------------------------------------
  assign boot_tgt = reson ? oss_pkg::OSS_COUNT : oss_pkg::OSS_RUN;
  assign evt = por_pulse | wake_pulse | (state_reg == oss_pkg::OSS_BOOT);
  assign cnt_next = cnt_reg + 11'h001;

  always_comb begin
    state_next = state_reg;
    if (por_pulse || state_reg == oss_pkg::OSS_BOOT) begin
      state_next = power_up_delay_timer_en_reg ? oss_pkg::OSS_WAIT : boot_tgt;
    end else if (wake_pulse) begin
      state_next = boot_tgt;
    end else begin
      case (state_reg)
        oss_pkg::OSS_WAIT: begin
          if (power_up_delay_timer_done) begin
            state_next = boot_tgt;
          end
        end
        oss_pkg::OSS_COUNT: begin
          if (xtal_edge && cnt_next == `OSS_STARTUP_CNT) begin
            state_next = oss_pkg::OSS_RUN;
          end
        end
        oss_pkg::OSS_RUN: state_next = oss_pkg::OSS_RUN;
        default: state_next = oss_pkg::OSS_BOOT;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= oss_pkg::OSS_BOOT;
      exec_hold <= 1'b1;
    end else begin
      state_reg <= state_next;
      exec_hold <= (state_next != oss_pkg::OSS_RUN);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= 11'h000;
    end else if (evt) begin
      cnt_reg <= 11'h000;
    end else if (state_reg == oss_pkg::OSS_COUNT && xtal_edge) begin
      cnt_reg <= cnt_next;
    end
  end

  assign startup_source_status_flag = (state_reg == oss_pkg::OSS_RUN) & ~sel_reg;

  // ----------------------------------------
  // divided clock output
  // ----------------------------------------
  assign ext_src  = ~sel_reg & (mode_reg < oss_pkg::OSS_INT_OUT);
  assign tick     = ext_src ? xtal_edge : int_edge;
  assign div_next = tick ? div_reg + 2'h1 : div_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_reg              <= 2'h0;
      crystal_output_pin_o <= 1'b0;
    end else begin
      div_reg              <= div_next;
      crystal_output_pin_o <= div_next[1];
    end
  end

  // ----------------------------------------
  // pin functions and oscillator controls
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      crystal_output_pin_oe <= 1'b0;
      out_pin_gpio          <= 1'b1;
      in_pin_gpio           <= 1'b1;
      amp_enable            <= 1'b0;
      amp_gain              <= `OSS_GAIN_OFF;
    end else begin
      crystal_output_pin_oe <= (mode_reg == oss_pkg::OSS_RESCAP) ||
                               (mode_reg == oss_pkg::OSS_INT_OUT);
      out_pin_gpio <= (mode_reg == oss_pkg::OSS_EXTCLK) ||
                      (mode_reg == oss_pkg::OSS_RCAP_IO) ||
                      (mode_reg == oss_pkg::OSS_INT_IO);
      in_pin_gpio  <= (mode_reg == oss_pkg::OSS_INT_OUT) ||
                      (mode_reg == oss_pkg::OSS_INT_IO);
      amp_enable   <= reson;
      case (mode_reg)
        oss_pkg::OSS_WATCH:  amp_gain <= `OSS_GAIN_LOW;
        oss_pkg::OSS_MEDIUM: amp_gain <= `OSS_GAIN_MID;
        oss_pkg::OSS_HIGH:   amp_gain <= `OSS_GAIN_HIGH;
        default:             amp_gain <= `OSS_GAIN_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fast_osc_enable    <= 1'b0;
      slow_osc_enable    <= 1'b0;
      postscale_shift    <= 3'h0;
      use_slow_osc       <= 1'b0;
      sys_clock_internal <= 1'b0;
    end else begin
      fast_osc_enable <= (ifs_reg != `OSS_IFS_SLOW) &&
                         (sel_reg || twospd_reg);
      slow_osc_enable <= ((ifs_reg == `OSS_IFS_SLOW) &&
                          (sel_reg || twospd_reg)) ||
                         power_up_delay_timer_en_reg || watchdog_enable;
      postscale_shift <= `OSS_IFS_TOP - ifs_reg;
      use_slow_osc    <= (ifs_reg == `OSS_IFS_SLOW);
      sys_clock_internal <= sel_reg ||
                            (twospd_reg && reson &&
                             state_next != oss_pkg::OSS_RUN);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence seq_last_edge;
    state_reg == oss_pkg::OSS_COUNT && cnt_reg == 11'h3ff &&
    xtal_edge && !por_pulse && !wake_pulse;
  endsequence

  sequence seq_reson_wake;
    wake_pulse && !por_pulse && reson &&
    state_reg != oss_pkg::OSS_BOOT;
  endsequence

  a_hold_during_count: assert property (
    state_reg == oss_pkg::OSS_COUNT |-> exec_hold)
    else $error("hold low while counting");

  a_count_release: assert property (
    seq_last_edge |=> !exec_hold && state_reg == oss_pkg::OSS_RUN)
    else $error("hold not released at terminal count");

  a_wake_restart: assert property (
    seq_reson_wake |=> state_reg == oss_pkg::OSS_COUNT && cnt_reg == 11'h000
    ##1 exec_hold)
    else $error("wake did not restart count");

  a_extclk_bypass: assert property (
    wake_pulse && !por_pulse && mode_reg == oss_pkg::OSS_EXTCLK &&
    state_reg != oss_pkg::OSS_BOOT |=> !exec_hold)
    else $error("external clock mode held execution");

  a_divided_clock_output_rise: assert property (
    tick && div_reg == 2'h1 |=> crystal_output_pin_o [*1])
    else $error("divided clock did not rise");

  a_divided_clock_output_fall: assert property (
    tick && div_reg == 2'h3 |=> !crystal_output_pin_o && div_reg == 2'h0)
    else $error("divided clock did not fall");

  a_fast_enable: assert property (
    ##1 fast_osc_enable == ($past(ifs_reg) != 3'h0 &&
    ($past(sel_reg) || $past(twospd_reg))))
    else $error("fast oscillator enable wrong");

  a_trim_write: assert property (
    wr_en && paddr == `OSS_ADDR_TRIM |=> trim_bits == $past(pwdata[4:0]))
    else $error("trim value not stored");

  a_startup_source_status_flag_internal: assert property (
    setup && !pwrite && paddr == `OSS_ADDR_CTRL && sel_reg
    |=> prdata[3] == 1'b0)
    else $error("start-up flag set on internal clock");

  a_freq_reset: assert property (
    $past(rst) |-> ifs_reg == 3'h6 && !sel_reg)
    else $error("frequency select reset value wrong");

  sequence seq_por_delay;
    por_pulse && power_up_delay_timer_en_reg;
  endsequence

  a_por_wait: assert property (
    seq_por_delay |=> state_reg == oss_pkg::OSS_WAIT && exec_hold)
    else $error("power-up delay not awaited");

  a_gain_low: assert property (
    mode_reg == oss_pkg::OSS_WATCH |=> amp_enable && amp_gain == `OSS_GAIN_LOW)
    else $error("watch crystal gain wrong");

  a_gain_high: assert property (
    mode_reg == oss_pkg::OSS_HIGH |=> amp_enable && amp_gain == `OSS_GAIN_HIGH)
    else $error("high drive gain wrong");

  a_ext_release: assert property (
    mode_reg == oss_pkg::OSS_EXTCLK |=> out_pin_gpio && !crystal_output_pin_oe)
    else $error("external clock output pin not released");

  a_rescap_drive: assert property (
    mode_reg == oss_pkg::OSS_RESCAP |=> crystal_output_pin_oe && !out_pin_gpio)
    else $error("divided clock not driven");

  a_out_release: assert property (
    mode_reg == oss_pkg::OSS_RCAP_IO |=> out_pin_gpio && !crystal_output_pin_oe)
    else $error("output pin not released");

  a_int_out_pins: assert property (
    mode_reg == oss_pkg::OSS_INT_OUT |=> crystal_output_pin_oe && in_pin_gpio)
    else $error("internal clock-out pins wrong");

  a_both_released: assert property (
    mode_reg == oss_pkg::OSS_INT_IO |=>
    out_pin_gpio && in_pin_gpio && !crystal_output_pin_oe)
    else $error("clock pins not released");

  a_trim_reset: assert property (
    $past(rst) |-> trim_bits == 5'h00)
    else $error("trim reset value wrong");

  a_slow_route: assert property (
    ##1 use_slow_osc == ($past(ifs_reg) == 3'h0))
    else $error("slow oscillator routing wrong");

  a_internal_select: assert property (
    sel_reg |=> sys_clock_internal)
    else $error("internal clock not selected");

endmodule

// File: bench/oss_osc_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// free-running source, still when not run
// ----------------------------------------
module oss_osc_model #(
  parameter int HALF_NS = 167
) (
  input  wire logic run,
  output logic      pin
);
  initial begin
    pin = 1'b0;
    forever begin
      #(HALF_NS);
      if (run) begin
        pin <= ~pin;
      end else begin
        pin <= 1'b0;
      end
    end
  end
endmodule

// File: bench/oss_top_tb_top.sv
`timescale 1ns/1ns
`include "oss_consts.svh"
module oss_top_tb_top;
  logic        clk_sys, clk_run, rst, psel, penable, pwrite, pready, pslverr, ev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        por_pulse, wake_pulse, power_up_delay_timer_done, watchdog_enable, fast_rdy, slow_rdy;
  logic        xtal, iclk, xrun, irun, exec_hold, amp_enable, fast_osc_enable;
  logic        slow_osc_enable, use_slow_osc, sys_clock_internal, dclk, dclk_oe;
  logic        out_pin_gpio, in_pin_gpio, watch;
  logic [1:0]  amp_gain;
  logic [2:0]  postscale_shift;
  logic [4:0]  trim_bits;
  int          errors, cmp_count, toggles;
  logic [5:0]  ptab [8] = '{6'h28, 6'h30, 6'h38, 6'h02, 6'h04, 6'h02, 6'h05, 6'h03};
  logic [31:0] tvals [4] = '{32'h0f, 32'h10, 32'hffffffff, 32'h0};

  oss_osc_model #(.HALF_NS(167)) xtal_u (.run(xrun), .pin(xtal));
  oss_osc_model #(.HALF_NS(181)) iclk_u (.run(irun), .pin(iclk));
  oss_top dut_u (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_pulse(por_pulse), .wake_pulse(wake_pulse), .power_up_delay_timer_done(power_up_delay_timer_done),
    .watchdog_enable(watchdog_enable), .crystal_input_pin(xtal), .internal_clock_pin(iclk),
    .fast_osc_ready(fast_rdy), .slow_osc_ready(slow_rdy), .exec_hold(exec_hold),
    .amp_enable(amp_enable), .amp_gain(amp_gain), .fast_osc_enable(fast_osc_enable),
    .slow_osc_enable(slow_osc_enable), .postscale_shift(postscale_shift),
    .use_slow_osc(use_slow_osc), .trim_bits(trim_bits),
    .sys_clock_internal(sys_clock_internal), .crystal_output_pin_o(dclk),
    .crystal_output_pin_oe(dclk_oe), .out_pin_gpio(out_pin_gpio), .in_pin_gpio(in_pin_gpio)
  );

  initial begin
    clk_sys = 1'b0;
    clk_run = 1'b1;
    forever #25 if (clk_run) clk_sys = ~clk_sys;
  end
  always @(dclk) if (watch) toggles++;

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int which);
    @(posedge clk_sys);
    if (which == 0) por_pulse <= 1'b1;
    else if (which == 1) wake_pulse <= 1'b1;
    else power_up_delay_timer_done <= 1'b1;
    @(posedge clk_sys);
    {por_pulse, wake_pulse, power_up_delay_timer_done} <= 3'h0;
  endtask
  task automatic held(input int n, input logic exp);
    xrun <= 1'b1;
    repeat (n) @(posedge xtal);
    @(posedge clk_sys);
    xrun <= 1'b0;
    cyc(10);
    chk("exec_hold", 32'(exec_hold), 32'(exp));
  endtask
  task automatic div_chk(input logic use_int);
    if (use_int) irun <= 1'b1;
    else xrun <= 1'b1;
    repeat (4) if (use_int) @(posedge iclk); else @(posedge xtal);
    cyc(5);
    toggles = 0;
    watch = 1'b1;
    repeat (16) if (use_int) @(posedge iclk); else @(posedge xtal);
    cyc(5);
    watch = 1'b0;
    irun <= 1'b0;
    xrun <= 1'b0;
    chk("div4", 32'(toggles), 32'h8);
  endtask
  task automatic end_sim();
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 8'h0, 32'h0};
    {por_pulse, wake_pulse, power_up_delay_timer_done, watchdog_enable} = 4'h0;
    {fast_rdy, slow_rdy, xrun, irun, watch} = 5'h18;
    {errors, cmp_count, toggles} = '0;
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    apb(1'b0, `OSS_ADDR_CTRL, 32'h0);
    chk("ctrl", rv, 32'h6e);
    apb(1'b0, `OSS_ADDR_TRIM, 32'h0);
    chk("trim", rv, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("err", 32'(ev), 32'h1);
    apb(1'b1, `OSS_ADDR_STAT, 32'h1);
    apb(1'b0, `OSS_ADDR_STAT, 32'h0);
    chk("stat", rv, 32'h0);
    fast_rdy <= 1'b0;
    cyc(5);
    apb(1'b0, `OSS_ADDR_CTRL, 32'h0);
    chk("ctrl", rv, 32'h6a);
    fast_rdy <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, `OSS_ADDR_CFG, 32'(m));
      cyc(2);
      chk("pins", 32'({amp_enable, amp_gain, dclk_oe, out_pin_gpio, in_pin_gpio}),
          32'(ptab[m]));
    end
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, `OSS_ADDR_CFG, 32'(7 + 8 * t));
      for (int v = 0; v < 8; v++) begin
        for (int s = 0; s < 2; s++) begin
          apb(1'b1, `OSS_ADDR_CTRL, 32'(16 * v + s));
          cyc(2);
          chk("shift", 32'(postscale_shift), 32'(7 - v));
          chk("slow", 32'(use_slow_osc), 32'(v == 0));
          chk("fast_en", 32'(fast_osc_enable), 32'(v != 0 && (s || t)));
          chk("slow_en", 32'(slow_osc_enable), 32'(v == 0 && (s || t)));
          chk("int", 32'(sys_clock_internal), 32'(s));
          apb(1'b0, `OSS_ADDR_CTRL, 32'h0);
          chk("ctrl", rv, 32'(16 * v + 8 * (1 - s) + 6 + s));
        end
      end
    end
    watchdog_enable <= 1'b1;
    cyc(2);
    chk("slow_en", 32'(slow_osc_enable), 32'h1);
    watchdog_enable <= 1'b0;
    foreach (tvals[i]) begin
      apb(1'b1, `OSS_ADDR_TRIM, tvals[i]);
      cyc(1);
      chk("trim_bits", 32'(trim_bits), 32'(tvals[i][4:0]));
      apb(1'b0, `OSS_ADDR_TRIM, 32'h0);
      chk("trim", rv, tvals[i] & 32'h1f);
    end
    apb(1'b1, `OSS_ADDR_TRIM, 32'h0b);
    @(posedge clk_sys);
    clk_run = 1'b0;
    #2000;
    clk_run = 1'b1;
    apb(1'b0, `OSS_ADDR_TRIM, 32'h0);
    chk("trim", rv, 32'h0b);
    apb(1'b1, `OSS_ADDR_CTRL, 32'h60);
    apb(1'b1, `OSS_ADDR_CFG, 32'h4);
    div_chk(1'b0);
    apb(1'b1, `OSS_ADDR_CFG, 32'h6);
    apb(1'b1, `OSS_ADDR_CTRL, 32'h61);
    div_chk(1'b1);
    apb(1'b1, `OSS_ADDR_CTRL, 32'h60);
    apb(1'b1, `OSS_ADDR_CFG, 32'h1);
    pulse(1);
    cyc(2);
    chk("exec_hold", 32'(exec_hold), 32'h1);
    held(600, 1'b1);
    pulse(1);
    held(1023, 1'b1);
    held(1, 1'b0);
    apb(1'b1, `OSS_ADDR_CFG, 32'h11);
    pulse(0);
    chk("slow_en", 32'(slow_osc_enable), 32'h1);
    held(1100, 1'b1);
    pulse(2);
    held(1023, 1'b1);
    held(1, 1'b0);
    apb(1'b1, `OSS_ADDR_CFG, 32'h9);
    pulse(1);
    apb(1'b0, `OSS_ADDR_STAT, 32'h0);
    chk("stat", rv, 32'h1);
    chk("fast_en", 32'(fast_osc_enable), 32'h1);
    chk("int", 32'(sys_clock_internal), 32'h1);
    apb(1'b1, `OSS_ADDR_CFG, 32'h3);
    pulse(1);
    cyc(2);
    chk("exec_hold", 32'(exec_hold), 32'h0);
    end_sim();
  end

  initial begin
    #4000000;
    errors++;
    end_sim();
  end
endmodule
